// ### ref_input_regs.svh
// Register map, field positions and reset values of the reference input control
// Notes on behaviour
// - Skip bit 1 bypasses the glitch-free mux
// - Keep-on 0: alt crystal buffer off after return
// - Keep-on 1: alt crystal buffer keeps running
// - Alt buffer gain: 0 minimum, 1 maximum
// - Main buffer gain: 0 minimum, 1 maximum
// - Predivider code N divides by N+1, 0 bypasses
`ifndef REF_INPUT_REGS_SVH
`define REF_INPUT_REGS_SVH
`define ADDR_INPUT_CLOCK_CONTROL 8'h33
`define ADDR_REFERENCE_PREDIVIDER 8'h34
`define ADDR_REF_STATUS 8'h35
`define BIT_REF_MUX_SKIP 7
`define BIT_ALT_XTAL_KEEP_ON 2
`define BIT_ALT_BUF_GAIN 1
`define BIT_MAIN_BUF_GAIN 0
`define RATIO_MSB 2
`define RATIO_LSB 0
`define BIT_STAT_ALT_ACTIVE 0
`define BIT_STAT_ALT_BUF_ON 1
`define BIT_STAT_MUX_BUSY 2
`define RST_REF_MUX_SKIP 1'b0
`define RST_ALT_XTAL_KEEP_ON 1'b0
`define RST_ALT_BUF_GAIN 1'b1
`define RST_MAIN_BUF_GAIN 1'b1
`define RST_RATIO 3'h0
`define RATIO_BYPASS 3'h0
`define READ_ZERO 8'h00
`endif

// ### ref_input_pkg.sv
// Shared types of the reference input control
package ref_input_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [7:0] reg_addr_t;
    typedef logic [2:0] ratio_t;
    typedef enum logic [1:0] {MUX_RUN, MUX_DRAIN, MUX_ARM} mux_state_t;
endpackage

// ### ref_clock_switch.sv
// Glitch-free switch between the main and alternate reference paths
`include "ref_input_regs.svh"
module ref_clock_switch
    import ref_input_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ref_main,
    input wire logic ref_alt,
    input wire logic want_alt,
    input wire logic skip,
    output logic ref_out,
    output logic alt_active,
    output logic busy
);
    mux_state_t state;
    logic gate_on;
    logic cur_level;

    assign cur_level = alt_active ? ref_alt : ref_main;
    assign busy = (state != MUX_RUN);

    // Unless skipped, gate opens and closes only while a path is low, so no runt pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= MUX_RUN;
            gate_on <= 1'b1;
            alt_active <= 1'b0;
        end else if (skip) begin
            state <= MUX_RUN;
            gate_on <= 1'b1;
            alt_active <= want_alt;
        end else begin
            case (state)
                MUX_RUN: begin
                    if (want_alt != alt_active && !cur_level) begin
                        gate_on <= 1'b0;
                        state <= MUX_DRAIN;
                    end
                end
                MUX_DRAIN: begin
                    alt_active <= want_alt;
                    state <= MUX_ARM;
                end
                MUX_ARM: begin
                    if (!cur_level) begin
                        gate_on <= 1'b1;
                        state <= MUX_RUN;
                    end
                end
                default: begin
                    state <= MUX_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_out <= 1'b0;
        end else if (skip) begin
            ref_out <= want_alt ? ref_alt : ref_main;
        end else begin
            ref_out <= gate_on & cur_level;
        end
    end

    chk_gate_close_low: assert property (@(posedge clk) disable iff (!reset_n)
        !skip && $fell(gate_on) |-> !ref_out)
        else $error("Mux gate closed while path was high");
    chk_skip_direct: assert property (@(posedge clk) disable iff (!reset_n)
        skip |=> ref_out == $past(want_alt ? ref_alt : ref_main))
        else $error("Bypassed mux did not pass selected path");
endmodule

// ### ref_predivide.sv
// Reference predivider, divides by code plus one
`include "ref_input_regs.svh"
module ref_predivide
    import ref_input_pkg::*;
#(
    parameter int RATIO_W = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ref_in,
    input wire logic [RATIO_W-1:0] ratio,
    output logic ref_div
);
    logic prev;
    logic [RATIO_W-1:0] cnt;
    logic [RATIO_W-1:0] ratio_q;
    logic edge_seen;

    assign edge_seen = ref_in ^ prev;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev <= 1'b0;
            ratio_q <= `RST_RATIO;
        end else begin
            prev <= ref_in;
            ratio_q <= ratio;
        end
    end

    // Counting both edges keeps a 50% duty for odd ratios too
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= `RATIO_BYPASS;
            ref_div <= 1'b0;
        end else if (ratio == `RATIO_BYPASS) begin
            cnt <= `RATIO_BYPASS;
            ref_div <= ref_in;
        end else if (ratio != ratio_q) begin
            cnt <= `RATIO_BYPASS;
        end else if (edge_seen) begin
            if (cnt == ratio) begin
                cnt <= `RATIO_BYPASS;
                ref_div <= ~ref_div;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    chk_div_bypass: assert property (@(posedge clk) disable iff (!reset_n)
        ratio == `RATIO_BYPASS |=> ref_div == $past(ref_in))
        else $error("Predivider bypass did not pass reference");
    chk_div_toggle: assert property (@(posedge clk) disable iff (!reset_n)
        ratio != `RATIO_BYPASS && ratio == ratio_q && edge_seen && cnt == ratio |=> ref_div != $past(ref_div))
        else $error("Predivider missed toggle after ratio plus one edges");
    chk_div_hold: assert property (@(posedge clk) disable iff (!reset_n)
        ratio != `RATIO_BYPASS && cnt != ratio |=> ref_div == $past(ref_div))
        else $error("Predivider toggled early");
endmodule

// ### ref_input_control.sv
// Reference input control: registers, alt buffer power, mux and predivider
//
// The implementer's own choice: the address-and-strobe port.
`include "ref_input_regs.svh"
module ref_input_control
    import ref_input_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic ref_main,
    input wire logic ref_alt,
    input wire logic want_alt,
    output logic ref_to_pll,
    output logic main_buf_gain,
    output logic alt_buf_gain,
    output logic alt_xtal_buf_on,
    output logic ref_mux_busy
);
    logic ref_mux_skip;
    logic alt_xtal_keep_on;
    ratio_t ref_predivide_ratio;
    logic alt_active;
    logic mux_out;
    logic mux_busy;
    logic next_alt_xtal_buf_on;
    reg_byte_t read_word;
    logic wr_ctl;
    logic wr_div;
    logic first_cycle;

    function automatic logic reg_hit(input reg_addr_t a, input reg_addr_t offset);
        return a == offset;
    endfunction

    assign wr_ctl = wr_stb && reg_hit(addr, `ADDR_INPUT_CLOCK_CONTROL);
    assign wr_div = wr_stb && reg_hit(addr, `ADDR_REFERENCE_PREDIVIDER);
    assign ref_mux_busy = mux_busy;

    // Control register; reserved bits are not stored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_mux_skip <= `RST_REF_MUX_SKIP;
        end else if (wr_ctl) begin
            ref_mux_skip <= wdata[`BIT_REF_MUX_SKIP];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_xtal_keep_on <= `RST_ALT_XTAL_KEEP_ON;
        end else if (wr_ctl) begin
            alt_xtal_keep_on <= wdata[`BIT_ALT_XTAL_KEEP_ON];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_buf_gain <= `RST_ALT_BUF_GAIN;
        end else if (wr_ctl) begin
            alt_buf_gain <= wdata[`BIT_ALT_BUF_GAIN];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            main_buf_gain <= `RST_MAIN_BUF_GAIN;
        end else if (wr_ctl) begin
            main_buf_gain <= wdata[`BIT_MAIN_BUF_GAIN];
        end
    end

    // Predivider code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_predivide_ratio <= `RST_RATIO;
        end else if (wr_div) begin
            ref_predivide_ratio <= wdata[`RATIO_MSB:`RATIO_LSB];
        end
    end

    // Unless skipped, buffer powers up ahead of a switch so the alt path is live when gated in
    always_comb begin
        next_alt_xtal_buf_on = alt_active | want_alt;
        if (alt_xtal_buf_on && alt_xtal_keep_on) begin
            next_alt_xtal_buf_on = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_xtal_buf_on <= 1'b0;
        end else begin
            alt_xtal_buf_on <= next_alt_xtal_buf_on;
        end
    end

    ref_clock_switch u_switch (
        .clk(clk),
        .reset_n(reset_n),
        .ref_main(ref_main),
        .ref_alt(ref_alt),
        .want_alt(want_alt),
        .skip(ref_mux_skip),
        .ref_out(mux_out),
        .alt_active(alt_active),
        .busy(mux_busy)
    );

    ref_predivide #(
        .RATIO_W(3)
    ) u_predivide (
        .clk(clk),
        .reset_n(reset_n),
        .ref_in(mux_out),
        .ratio(ref_predivide_ratio),
        .ref_div(ref_to_pll)
    );

    // Read mux; unmapped addresses and reserved bits read as zero
    always_comb begin
        read_word = `READ_ZERO;
        if (reg_hit(addr, `ADDR_INPUT_CLOCK_CONTROL)) begin
            read_word[`BIT_REF_MUX_SKIP] = ref_mux_skip;
            read_word[`BIT_ALT_XTAL_KEEP_ON] = alt_xtal_keep_on;
            read_word[`BIT_ALT_BUF_GAIN] = alt_buf_gain;
            read_word[`BIT_MAIN_BUF_GAIN] = main_buf_gain;
        end else if (reg_hit(addr, `ADDR_REFERENCE_PREDIVIDER)) begin
            read_word[`RATIO_MSB:`RATIO_LSB] = ref_predivide_ratio;
        end else if (reg_hit(addr, `ADDR_REF_STATUS)) begin
            read_word[`BIT_STAT_ALT_ACTIVE] = alt_active;
            read_word[`BIT_STAT_ALT_BUF_ON] = alt_xtal_buf_on;
            read_word[`BIT_STAT_MUX_BUSY] = mux_busy;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= `READ_ZERO;
        end else if (rd_stb) begin
            rdata <= read_word;
        end else begin
            rdata <= `READ_ZERO;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_ctl_write;
        wr_ctl;
    endsequence

    sequence s_back_to_main;
        $fell(alt_active) && !want_alt;
    endsequence

    sequence s_div_write;
        wr_div;
    endsequence

    sequence s_ctl_read;
        rd_stb && reg_hit(addr, `ADDR_INPUT_CLOCK_CONTROL);
    endsequence

    sequence s_div_read;
        rd_stb && reg_hit(addr, `ADDR_REFERENCE_PREDIVIDER);
    endsequence

    sequence s_stat_read;
        rd_stb && reg_hit(addr, `ADDR_REF_STATUS);
    endsequence

    sequence s_unmapped_read;
        rd_stb && !reg_hit(addr, `ADDR_INPUT_CLOCK_CONTROL) && !reg_hit(addr, `ADDR_REFERENCE_PREDIVIDER)
            && !reg_hit(addr, `ADDR_REF_STATUS);
    endsequence

    sequence s_direct_main;
        ref_mux_skip && !want_alt && ref_predivide_ratio == `RATIO_BYPASS ##1 ref_predivide_ratio == `RATIO_BYPASS;
    endsequence

    chk_reset_defaults: assert property (
        first_cycle |-> !ref_mux_skip && !alt_xtal_keep_on && alt_buf_gain && main_buf_gain
            && ref_predivide_ratio == `RST_RATIO && !alt_xtal_buf_on)
        else $error("Defaults not applied after reset");
    chk_reserved_zero: assert property (
        rd_stb && reg_hit(addr, `ADDR_REFERENCE_PREDIVIDER) |=> rdata[7:3] == 5'h0)
        else $error("Reserved predivider bits not zero");
    chk_ctl_reserved: assert property (
        rd_stb && reg_hit(addr, `ADDR_INPUT_CLOCK_CONTROL) |=> rdata[6:3] == 4'h0)
        else $error("Reserved control bits not zero");
    chk_skip_written: assert property (
        s_ctl_write |=> ref_mux_skip == $past(wdata[`BIT_REF_MUX_SKIP]))
        else $error("Mux skip bit not taken");
    chk_alt_off_return: assert property (
        s_back_to_main ##0 !alt_xtal_keep_on |=> !alt_xtal_buf_on)
        else $error("Alt crystal buffer left on after return");
    chk_alt_keep_on: assert property (
        alt_xtal_buf_on && alt_xtal_keep_on |=> alt_xtal_buf_on [*1])
        else $error("Alt crystal buffer dropped with keep-on set");
    chk_alt_gain_follow: assert property (
        s_ctl_write |=> alt_buf_gain == $past(wdata[`BIT_ALT_BUF_GAIN]) ##1 ($stable(alt_buf_gain) || $past(wr_ctl)))
        else $error("Alt buffer gain not applied");
    chk_main_gain_follow: assert property (
        s_ctl_write |=> main_buf_gain == $past(wdata[`BIT_MAIN_BUF_GAIN]))
        else $error("Main buffer gain not applied");
    chk_ratio_readback: assert property (
        wr_div ##1 rd_stb && reg_hit(addr, `ADDR_REFERENCE_PREDIVIDER) |=> rdata[2:0] == $past(wdata[2:0], 2))
        else $error("Predivider code readback wrong");
    chk_read_one_cycle: assert property (
        !rd_stb |=> rdata == `READ_ZERO)
        else $error("Read data held past its cycle");

    chk_reset_rdata: assert property (
        first_cycle |-> rdata == `READ_ZERO)
        else $error("Read data not zero after reset");

    // Fields move only on a write to their own offset
    chk_keep_on_written: assert property (
        s_ctl_write |=> alt_xtal_keep_on == $past(wdata[`BIT_ALT_XTAL_KEEP_ON]))
        else $error("Keep-on bit not taken");

    chk_ratio_written: assert property (
        s_div_write |=> ref_predivide_ratio == $past(wdata[`RATIO_MSB:`RATIO_LSB]))
        else $error("Predivider code not taken");

    chk_skip_hold: assert property (
        !wr_ctl |=> $stable(ref_mux_skip))
        else $error("Mux skip bit moved without a write");

    chk_keep_on_hold: assert property (
        !wr_ctl |=> $stable(alt_xtal_keep_on))
        else $error("Keep-on bit moved without a write");

    chk_gain_hold: assert property (
        !wr_ctl |=> $stable(alt_buf_gain) && $stable(main_buf_gain))
        else $error("Buffer gain moved without a write");

    chk_ratio_hold: assert property (
        !wr_div |=> $stable(ref_predivide_ratio))
        else $error("Predivider code moved without a write");

    chk_ctl_readback: assert property (
        s_ctl_read |=> rdata[`BIT_REF_MUX_SKIP] == $past(ref_mux_skip)
            && rdata[`BIT_ALT_XTAL_KEEP_ON] == $past(alt_xtal_keep_on)
            && rdata[`BIT_ALT_BUF_GAIN] == $past(alt_buf_gain) && rdata[`BIT_MAIN_BUF_GAIN] == $past(main_buf_gain))
        else $error("Control readback wrong");

    chk_div_readback: assert property (
        s_div_read |=> rdata[`RATIO_MSB:`RATIO_LSB] == $past(ref_predivide_ratio))
        else $error("Predivider readback wrong");

    chk_stat_alt: assert property (
        s_stat_read |=> rdata[`BIT_STAT_ALT_ACTIVE] == $past(alt_active))
        else $error("Status path bit wrong");

    chk_stat_buf: assert property (
        s_stat_read |=> rdata[`BIT_STAT_ALT_BUF_ON] == $past(alt_xtal_buf_on))
        else $error("Status buffer bit wrong");

    chk_stat_busy: assert property (
        s_stat_read |=> rdata[`BIT_STAT_MUX_BUSY] == $past(mux_busy))
        else $error("Status busy bit wrong");

    chk_stat_reserved: assert property (
        s_stat_read |=> rdata[7:3] == 5'h0)
        else $error("Reserved status bits not zero");

    chk_unmapped_zero: assert property (
        s_unmapped_read |=> rdata == `READ_ZERO)
        else $error("Unmapped read not zero");

    // Buffer must be up before the alt path can be gated in
    chk_buf_on_want: assert property (
        want_alt |=> alt_xtal_buf_on)
        else $error("Alt buffer off while alt wanted");

    chk_buf_on_alt: assert property (
        alt_active |=> alt_xtal_buf_on)
        else $error("Alt buffer off while alt in use");

    chk_buf_drop: assert property (
        !alt_xtal_keep_on && !alt_active && !want_alt |=> !alt_xtal_buf_on)
        else $error("Alt buffer on with nothing to keep it");

    chk_skip_not_busy: assert property (
        ref_mux_skip |=> !mux_busy)
        else $error("Bypassed mux shows busy");

    chk_skip_follow: assert property (
        ref_mux_skip |=> alt_active == $past(want_alt))
        else $error("Bypassed mux did not follow selection");

    chk_direct_main: assert property (
        s_direct_main |=> ref_to_pll == $past(ref_main, 2))
        else $error("Direct main path not two cycles behind");
endmodule

// ### ref_input_control_bench.sv
// Self-checking bench of the reference input control
`include "ref_input_regs.svh"
module ref_input_control_bench
    import ref_input_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {reg_addr_t a; reg_byte_t w; reg_byte_t r; logic [1:0] g;} row_t;
    logic clk, reset_n, wr_stb, rd_stb, ref_main, ref_alt, want_alt, toggle, got;
    logic ref_to_pll, main_buf_gain, alt_buf_gain, alt_xtal_buf_on, ref_mux_busy;
    reg_addr_t addr;
    reg_byte_t wdata, rdata, d;
    int fail_count, checks, cycles, p;
    row_t rows [6] = '{
        '{`ADDR_INPUT_CLOCK_CONTROL, 8'hff, 8'h87, 2'h3},
        '{`ADDR_INPUT_CLOCK_CONTROL, 8'h02, 8'h02, 2'h2},
        '{`ADDR_INPUT_CLOCK_CONTROL, 8'h01, 8'h01, 2'h1},
        '{`ADDR_REFERENCE_PREDIVIDER, 8'hff, 8'h07, 2'h1},
        '{`ADDR_REFERENCE_PREDIVIDER, 8'h05, 8'h05, 2'h1},
        '{8'h40, 8'haa, 8'h00, 2'h1}};

    ref_input_control DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ref_main(ref_main), .ref_alt(ref_alt),
        .want_alt(want_alt), .ref_to_pll(ref_to_pll), .main_buf_gain(main_buf_gain),
        .alt_buf_gain(alt_buf_gain), .alt_xtal_buf_on(alt_xtal_buf_on), .ref_mux_busy(ref_mux_busy));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Free toggling reference, and a ceiling well above the run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (toggle) begin
            ref_main <= ~ref_main;
            ref_alt <= ~ref_alt;
        end
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic check(input reg_byte_t seen, input reg_byte_t exp);
        checks++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic test_done();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input reg_addr_t a, input reg_byte_t w);
        @(posedge clk);
        addr <= a;
        wdata <= w;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // Starts at once, so a read may follow a write with no gap
    task automatic rd(input reg_addr_t a, output reg_byte_t r);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 r = rdata;
    endtask

    // Bounded wait for a level: 0 busy, 1 alt buffer, 2 reference out
    task automatic wait_on(input int sel, input logic v, input int lim);
        logic s;
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk);
            #1;
            case (sel)
                0: s = ref_mux_busy;
                1: s = alt_xtal_buf_on;
                default: s = ref_to_pll;
            endcase
            got = (s === v);
        end
    endtask

    // Cycles between two rising edges of the reference out
    task automatic period();
        logic prev;
        int start;
        p = 0;
        start = -1;
        prev = ref_to_pll;
        for (int n = 0; n < 100 && p == 0; n++) begin
            @(posedge clk);
            #1;
            if (ref_to_pll === 1'b1 && prev === 1'b0) begin
                if (start >= 0)
                    p = n - start;
                else
                    start = n;
            end
            prev = ref_to_pll;
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        check({3'h0, ref_to_pll, main_buf_gain, alt_buf_gain, alt_xtal_buf_on, ref_mux_busy}, 8'h0c);
        check(rdata, 8'h00);
        reset_n <= 1'b1;
        rd(`ADDR_INPUT_CLOCK_CONTROL, d);
        check(d, 8'h03);
        rd(`ADDR_REFERENCE_PREDIVIDER, d);
        check(d, 8'h00);
    endtask

    initial begin
        reset_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        ref_main = 1'b0;
        ref_alt = 1'b0;
        want_alt = 1'b0;
        toggle = 1'b0;
        fail_count = 0;
        checks = 0;
        cycles = 0;
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            check(d, rows[i].r);
            check({6'h0, alt_buf_gain, main_buf_gain}, {6'h0, rows[i].g});
        end
        wr(`ADDR_INPUT_CLOCK_CONTROL, 8'h03);
        toggle <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            wr(`ADDR_REFERENCE_PREDIVIDER, 8'(n));
            period();
            check(8'(p), 8'(2 * n + 2));
        end
        wr(`ADDR_REFERENCE_PREDIVIDER, 8'h00);
        @(posedge clk);
        want_alt <= 1'b1;
        wait_on(0, 1'b1, 6);
        check({7'h0, got}, 8'h01);
        wait_on(0, 1'b0, 12);
        check({7'h0, got}, 8'h01);
        rd(`ADDR_REF_STATUS, d);
        check(d, 8'h03);
        // Bypassed switch back must never show the mux busy
        wr(`ADDR_INPUT_CLOCK_CONTROL, 8'h83);
        @(posedge clk);
        want_alt <= 1'b0;
        wait_on(0, 1'b1, 8);
        check({7'h0, got}, 8'h00);
        wait_on(1, 1'b0, 6);
        check({7'h0, got}, 8'h01);
        toggle <= 1'b0;
        ref_main <= 1'b1;
        ref_alt <= 1'b0;
        wait_on(2, 1'b1, 4);
        check({7'h0, got}, 8'h01);
        // Main held high: a gated mux could not leave it
        @(posedge clk);
        want_alt <= 1'b1;
        wait_on(2, 1'b0, 4);
        check({7'h0, got}, 8'h01);
        wr(`ADDR_INPUT_CLOCK_CONTROL, 8'h87);
        @(posedge clk);
        want_alt <= 1'b0;
        repeat (10) @(posedge clk);
        #1 check({7'h0, alt_xtal_buf_on}, 8'h01);
        wr(`ADDR_INPUT_CLOCK_CONTROL, 8'h83);
        wait_on(1, 1'b0, 3);
        check({7'h0, got}, 8'h01);
        wr(`ADDR_REFERENCE_PREDIVIDER, 8'h07);
        do_reset();
        test_done();
    end
endmodule
